// [csip_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module csip_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push, pop;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		in_ready_o  = (cnt_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
		out_valid_o = (cnt_q != '0);
		out_data_o  = mem_q[rd_q];
		push        = in_valid_i && in_ready_o;
		pop         = out_valid_o && out_ready_i;
		mem_d       = mem_q;
		wr_d        = wr_q;
		rd_d        = rd_q;
		cnt_d       = cnt_q;
		if (push) begin
			mem_d[wr_q] = in_data_i;
			wr_d        = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
		end
		if (pop) begin
			rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
		end
		if (push && !pop) begin
			cnt_d = cnt_q + (AW+1)'(1);
		end else if (pop && !push) begin
			cnt_d = cnt_q - (AW+1)'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			mem_q <= mem_d;
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

endmodule : csip_fifo

// [csip_pkg.sv]
// Package for the complex sample input port
package csip_pkg;

	// Sample widths
	localparam int IN_W   = 12;
	localparam int FRAC_W = 17;
	localparam int OUT_W  = 1 + FRAC_W;
	localparam int GAIN_W = 12;

	// FIFO shape
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_W     = 2 * OUT_W;

	// Clock and timing
	localparam int CLK_HZ          = 25_000_000;
	localparam int GAIN_UPD_US     = 10;
	localparam int GAIN_UPD_CYC    = (CLK_HZ / 1_000_000) * GAIN_UPD_US;
	localparam int GAIN_CNT_W      = 9;

	// Reset values and levels
	localparam logic [GAIN_W-1:0] GAIN_RST  = 12'h0000;
	localparam logic [GAIN_W-1:0] GAIN_STEP = 12'h0010;
	localparam logic [OUT_W-1:0]  HI_LEVEL  = 18'h1_0000;
	localparam logic [OUT_W-1:0]  LO_LEVEL  = 18'h0_4000;

	// Gain loop states
	typedef enum logic [2:0] {
		GS_IDLE  = 3'b001,
		GS_MEAS  = 3'b010,
		GS_ADJ   = 3'b100
	} csip_gstate_e;

endpackage : csip_pkg

// [csip_src.sv]
// Upstream sample source model
`timescale 1ns/1ps
module csip_src
	import csip_pkg::*;
(
	input  wire logic            clk_i,
	output logic      [IN_W-1:0] data_i_o,
	output logic      [IN_W-1:0] data_q_o,
	output logic                 valid_o
);
	initial begin
		data_i_o = 12'h0A5;
		data_q_o = 12'h05A;
		valid_o = 1'b0;
	end
	task automatic send(logic [IN_W-1:0] i, q);
		@(posedge clk_i);
		data_i_o <= i;
		data_q_o <= q;
		valid_o <= 1'b1;
	endtask : send
	task automatic idle(int n);
		repeat (n) begin
			@(posedge clk_i);
			data_i_o <= ~data_i_o;
			data_q_o <= ~data_q_o;
			valid_o <= 1'b0;
		end
	endtask : idle
endmodule : csip_src

// [csip_top.sv]
// Complex sample input port: capture, convert, buffer, gain control
// Behaviour
// - Capture I and Q only on clock edges where sample valid is high.
// - Inputs are separate 12-bit unsigned I and Q words.
// - Undriven low input bits count as zero.
// - Overflowing results clamp to largest positive or negative value.
// - Clamped results keep the sign of the true result.
// - Internal samples use x.y fixed point; here 1.17 signed.
// - Gain output low means maximum gain, high means minimum gain.
// - Processing clock is fixed; input rate stays just below it.
`timescale 1ns/1ps
module csip_top
	import csip_pkg::*;
#(
	parameter int IN_BITS = csip_pkg::IN_W
) (
	// Clock and reset
	input  wire logic                          CLOCK_I,
	input  wire logic                          SYS_RST_I,
	// Sample input
	input  wire logic [csip_pkg::IN_W-1:0]     DATA_I_I,
	input  wire logic [csip_pkg::IN_W-1:0]     DATA_Q_I,
	input  wire logic                          SAMPLE_VALID_I,
	// Gain scale applied to captured samples, 1.17 unsigned-in-signed
	input  wire logic [csip_pkg::OUT_W-1:0]    GAIN_SCALE_I,
	// Sample output
	output logic                               SAMPLE_VALID_O,
	input  wire logic                          SAMPLE_READY_I,
	output logic      [csip_pkg::OUT_W-1:0]    SAMPLE_I_O,
	output logic      [csip_pkg::OUT_W-1:0]    SAMPLE_Q_O,
	// Status
	output logic                               INPUT_READY_O,
	output logic                               OVERFLOW_O,
	output logic                               DROP_O,
	// Gain control toward the upstream receiver
	output logic      [csip_pkg::GAIN_W-1:0]   UPSTREAM_GAIN_CONTROL_O
);
	import csip_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Signals
	logic [IN_W-1:0]   in_i_q, in_i_d, in_q_q, in_q_d;
	logic              cap_q, cap_d;
	logic [OUT_W-1:0]  sc_i_q, sc_i_d, sc_q_q, sc_q_d;
	logic              sc_v_q, sc_v_d;
	logic              ovf_q, ovf_d, drop_q, drop_d;
	logic [IN_W-1:0]   mask_in;
	logic [OUT_W-1:0]  sgn_i, sgn_q;
	logic              ff_in_ready, ff_out_valid;
	logic [FIFO_W-1:0] ff_out_data;
	logic              ovf_i, ovf_qq;
	logic [OUT_W-1:0]  sat_i, sat_q;

	csip_gstate_e         gs_q, gs_d;
	logic [GAIN_W-1:0]    gain_q, gain_d;
	logic [GAIN_CNT_W-1:0] gcnt_q, gcnt_d;
	logic                 seen_hi_q, seen_hi_d, seen_lo_q, seen_lo_d;

	// Fixed-point multiply of a signed 1.17 sample by an unsigned scale
	function automatic logic [OUT_W-1:0] scale_sat(
		input  logic [OUT_W-1:0] x,
		input  logic [OUT_W-1:0] g,
		output logic             ovf
	);
		logic signed [2*OUT_W+1:0] prod;
		logic signed [2*OUT_W+1:0] shr;
		prod = $signed({{(OUT_W+2){x[OUT_W-1]}}, x}) * $signed({{(OUT_W+2){1'b0}}, g});
		shr  = prod >>> FRAC_W;
		ovf  = 1'b0;
		if (shr > $signed({{(OUT_W+3){1'b0}}, {(OUT_W-1){1'b1}}})) begin
			ovf       = 1'b1;
			scale_sat = {1'b0, {(OUT_W-1){1'b1}}};
		end else if (shr < -$signed({{(OUT_W+3){1'b0}}, 1'b1, {(OUT_W-1){1'b0}}})) begin
			ovf       = 1'b1;
			scale_sat = {1'b1, {(OUT_W-1){1'b0}}};
		end else begin
			scale_sat = shr[OUT_W-1:0];
		end
	endfunction : scale_sat

	////////////////////////////////////////////////////////////////////////
	// Capture and conversion
	always_comb begin
		mask_in = ~IN_W'((1 << (IN_W - IN_BITS)) - 1);
		in_i_d  = in_i_q;
		in_q_d  = in_q_q;
		cap_d   = SAMPLE_VALID_I;
		if (SAMPLE_VALID_I) begin
			in_i_d = DATA_I_I & mask_in;
			in_q_d = DATA_Q_I & mask_in;
		end
		sgn_i  = {~in_i_q[IN_W-1], in_i_q[IN_W-2:0], {(OUT_W-IN_W){1'b0}}};
		sgn_q  = {~in_q_q[IN_W-1], in_q_q[IN_W-2:0], {(OUT_W-IN_W){1'b0}}};
		sat_i  = scale_sat(sgn_i, GAIN_SCALE_I, ovf_i);
		sat_q  = scale_sat(sgn_q, GAIN_SCALE_I, ovf_qq);
		sc_v_d = cap_q;
		sc_i_d = cap_q ? sat_i : sc_i_q;
		sc_q_d = cap_q ? sat_q : sc_q_q;
		ovf_d  = ovf_q | (cap_q & (ovf_i | ovf_qq));
		drop_d = drop_q | (sc_v_q & ~ff_in_ready);
	end

	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			in_i_q <= '0;
			in_q_q <= '0;
			cap_q  <= 1'b0;
			sc_i_q <= '0;
			sc_q_q <= '0;
			sc_v_q <= 1'b0;
			ovf_q  <= 1'b0;
			drop_q <= 1'b0;
		end else begin
			in_i_q <= in_i_d;
			in_q_q <= in_q_d;
			cap_q  <= cap_d;
			sc_i_q <= sc_i_d;
			sc_q_q <= sc_q_d;
			sc_v_q <= sc_v_d;
			ovf_q  <= ovf_d;
			drop_q <= drop_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output buffer
	csip_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (CLOCK_I),
		.rst_i       (SYS_RST_I),
		.in_valid_i  (sc_v_q),
		.in_ready_o  (ff_in_ready),
		.in_data_i   ({sc_i_q, sc_q_q}),
		.out_valid_o (ff_out_valid),
		.out_ready_i (SAMPLE_READY_I),
		.out_data_o  (ff_out_data)
	);

	assign SAMPLE_VALID_O = ff_out_valid;
	assign SAMPLE_I_O     = ff_out_data[FIFO_W-1:OUT_W];
	assign SAMPLE_Q_O     = ff_out_data[OUT_W-1:0];
	assign INPUT_READY_O  = ff_in_ready;
	assign OVERFLOW_O     = ovf_q;
	assign DROP_O         = drop_q;

	////////////////////////////////////////////////////////////////////////
	// Gain control loop
	always_comb begin
		gs_d      = gs_q;
		gain_d    = gain_q;
		gcnt_d    = gcnt_q;
		seen_hi_d = seen_hi_q;
		seen_lo_d = seen_lo_q;
		unique case (gs_q)
			GS_IDLE: begin
				gcnt_d    = '0;
				seen_hi_d = 1'b0;
				seen_lo_d = 1'b0;
				gs_d      = GS_MEAS;
			end
			GS_MEAS: begin
				gcnt_d = gcnt_q + GAIN_CNT_W'(1);
				if (cap_q) begin
					if ((sgn_i[OUT_W-1] ? -sgn_i : sgn_i) >= HI_LEVEL ||
					    (sgn_q[OUT_W-1] ? -sgn_q : sgn_q) >= HI_LEVEL) begin
						seen_hi_d = 1'b1;
					end
					if ((sgn_i[OUT_W-1] ? -sgn_i : sgn_i) >= LO_LEVEL ||
					    (sgn_q[OUT_W-1] ? -sgn_q : sgn_q) >= LO_LEVEL) begin
						seen_lo_d = 1'b1;
					end
				end
				if (gcnt_q == GAIN_CNT_W'(GAIN_UPD_CYC - 1)) begin
					gs_d = GS_ADJ;
				end
			end
			GS_ADJ: begin
				if (seen_hi_q) begin
					gain_d = (gain_q > ~GAIN_STEP) ? '1 : gain_q + GAIN_STEP;
				end else if (!seen_lo_q) begin
					gain_d = (gain_q < GAIN_STEP) ? '0 : gain_q - GAIN_STEP;
				end
				gs_d = GS_IDLE;
			end
			default: gs_d = GS_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			gs_q      <= GS_IDLE;
			gain_q    <= GAIN_RST;
			gcnt_q    <= '0;
			seen_hi_q <= 1'b0;
			seen_lo_q <= 1'b0;
		end else begin
			gs_q      <= gs_d;
			gain_q    <= gain_d;
			gcnt_q    <= gcnt_d;
			seen_hi_q <= seen_hi_d;
			seen_lo_q <= seen_lo_d;
		end
	end

	assign UPSTREAM_GAIN_CONTROL_O = gain_q;

endmodule : csip_top

// [csip_top_sva.sv]
// Assertion checker for the complex sample input port
`timescale 1ns/1ps
module csip_top_sva
	import csip_pkg::*;
(
	input wire logic              CLOCK_I,
	input wire logic              SYS_RST_I,
	input wire logic              SAMPLE_VALID_I,
	input wire logic [OUT_W-1:0]  GAIN_SCALE_I,
	input wire logic              SAMPLE_VALID_O,
	input wire logic              SAMPLE_READY_I,
	input wire logic [OUT_W-1:0]  SAMPLE_I_O,
	input wire logic [OUT_W-1:0]  SAMPLE_Q_O,
	input wire logic              INPUT_READY_O,
	input wire logic              OVERFLOW_O,
	input wire logic              DROP_O,
	input wire logic [GAIN_W-1:0] UPSTREAM_GAIN_CONTROL_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	AST_LATENCY: assert property (SAMPLE_VALID_I && !SAMPLE_VALID_O |-> ##3 SAMPLE_VALID_O)
		else $error("sample not delivered in 3 cycles");
	AST_NO_GHOST: assert property (!SAMPLE_VALID_I [*3] ##0 !SAMPLE_VALID_O |=> !SAMPLE_VALID_O)
		else $error("sample appeared without strobe");
	AST_PAIR_HOLD: assert property (SAMPLE_VALID_O && !SAMPLE_READY_I |=>
		SAMPLE_VALID_O && $stable(SAMPLE_I_O) && $stable(SAMPLE_Q_O))
		else $error("sample pair changed while stalled");
	AST_OVF_STICKY: assert property (OVERFLOW_O |=> OVERFLOW_O)
		else $error("overflow flag cleared");
	AST_OVF_CAUSE: assert property ($rose(OVERFLOW_O) |-> $past(GAIN_SCALE_I[OUT_W-1]))
		else $error("overflow without gain above one");
	AST_DROP_CAUSE: assert property ($rose(DROP_O) |-> !$past(INPUT_READY_O) && SAMPLE_VALID_O)
		else $error("drop while buffer had room");
	AST_GAIN_STEP: assert property ($changed(UPSTREAM_GAIN_CONTROL_O) |->
		(UPSTREAM_GAIN_CONTROL_O - $past(UPSTREAM_GAIN_CONTROL_O)) inside {12'h010, 12'hFF0})
		else $error("gain moved by other than one step");
	AST_GAIN_HOLD: assert property ($changed(UPSTREAM_GAIN_CONTROL_O) |=> $stable(UPSTREAM_GAIN_CONTROL_O) [*8])
		else $error("gain updated too often");
endmodule : csip_top_sva
bind csip_top csip_top_sva u_sva (.*);

// [csip_top_test.sv]
// Testbench for the complex sample input port
`timescale 1ns/1ps
module csip_top_test;
	import csip_pkg::*;
	logic                 clk = 0, rst, rdy, sv, vo, ir, ovf, drp;
	logic [OUT_W-1:0]     sc, so_i, so_q;
	logic [IN_W-1:0]      di, dq;
	logic [GAIN_W-1:0]    gn;
	logic [2*OUT_W-1:0]   q[$];
	int                   err_count = 0, compares = 0;
	always #20 clk = ~clk;
	csip_src u_src (.clk_i(clk), .data_i_o(di), .data_q_o(dq), .valid_o(sv));
	csip_top #(.IN_BITS(10)) u_dut (.CLOCK_I(clk), .SYS_RST_I(rst), .DATA_I_I(di), .DATA_Q_I(dq),
		.SAMPLE_VALID_I(sv), .GAIN_SCALE_I(sc), .SAMPLE_VALID_O(vo), .SAMPLE_READY_I(rdy), .SAMPLE_I_O(so_i),
		.SAMPLE_Q_O(so_q), .INPUT_READY_O(ir), .OVERFLOW_O(ovf), .DROP_O(drp), .UPSTREAM_GAIN_CONTROL_O(gn));
	function automatic logic [OUT_W-1:0] ex(logic [IN_W-1:0] d);
		logic [IN_W-1:0] m;
		logic signed [OUT_W-1:0] x;
		longint p;
		m = d & 12'hFFC;
		x = {~m[11], m[10:0], 6'h00};
		p = (longint'(x) * longint'(sc)) >>> 17;
		if (p > 64'sh1_FFFF) p = 64'sh1_FFFF;
		if (p < -64'sh2_0000) p = -64'sh2_0000;
		return p[OUT_W-1:0];
	endfunction : ex
	task automatic chk(string n, logic [OUT_W-1:0] e, s);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic snd(logic [IN_W-1:0] i, qv);
		q.push_back({ex(i), ex(qv)});
		u_src.send(i, qv);
	endtask : snd
	task automatic drain();
		rdy <= 1'b1;
		for (int k = 0; k < 200 && q.size() > 0; k++) @(posedge clk);
		chk("queue_left", 0, q.size());
	endtask : drain
	always @(posedge clk) if (vo === 1'b1 && rdy === 1'b1) begin
		if (q.size() == 0) chk("extra_sample", 0, 1);
		else begin
			chk("sample_i", q[0][2*OUT_W-1:OUT_W], so_i);
			chk("sample_q", q[0][OUT_W-1:0], so_q);
			void'(q.pop_front());
		end
	end
	task automatic t_conv();
		logic [IN_W-1:0] v[5] = '{12'h000, 12'h800, 12'hFFF, 12'h7FF, 12'h5A3};
		rdy <= 1'b1;
		foreach (v[k]) begin
			snd(v[k], ~v[k]);
			u_src.idle(2);
		end
		drain();
		chk("overflow", 0, ovf);
		sc <= 18'h3_FFFF;
		@(posedge clk);
		foreach (v[k]) snd(v[k], v[4-k]);
		u_src.idle(1);
		drain();
		chk("overflow", 1, ovf);
	endtask : t_conv
	task automatic t_fifo();
		rdy <= 1'b0;
		for (int k = 0; k < FIFO_DEPTH; k++) snd(12'h100 + 12'(k), 12'hE00 - 12'(k));
		u_src.idle(4);
		chk("in_ready", 0, ir);
		u_src.send(12'h444, 12'h444);
		u_src.idle(4);
		chk("drop", 1, drp);
		drain();
		@(posedge clk);
		#1;
		chk("valid_out", 0, vo);
	endtask : t_fifo
	task automatic t_gain();
		rst <= 1'b1;
		sc <= 18'h1_FFFF;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk("gain", 0, gn);
		rdy <= 1'b1;
		repeat (520) snd(12'hFFF, 12'h000);
		chk("gain", 12'h020, gn);
		u_src.idle(1100);
		chk("gain", 0, gn);
	endtask : t_gain
	task automatic finish_test();
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test
	initial begin
		rst = 1'b1;
		rdy = 1'b0;
		sc  = 18'h1_0000;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("in_ready", 1, ir);
		t_conv();
		t_fifo();
		t_gain();
		finish_test();
	end
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		finish_test();
	end
endmodule : csip_top_test
